//--- sim/fser_host_spi.sv
// Purpose: drive controller side, opens an SPI transfer every eighth cycle
// Assumes: transfer start is a one-cycle pulse
// Notes: captured status is judged by the checker
`timescale 1ns/1ps
module fser_host_spi (
    input wire i_core_clk,
    input wire i_rst,
    output reg o_spi_xfer
);
    reg [2:0] cnt_r;
    always @(posedge i_core_clk)
    begin
        cnt_r <= i_rst ? 3'h0 : cnt_r + 3'h1;
        o_spi_xfer <= !i_rst && cnt_r == 3'h6;
    end
endmodule

//--- sim/fser_properties.sv
// Purpose: port-level checks of fser_top
// Assumes: bound inside fser_top, one clock, synchronous reset
// Notes: remote wait comes in through the bind parameter
`timescale 1ns/1ps
module fser_chk #(
    parameter P_REMOTE_WAIT_CYC = 4
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [7:0] i_crit_cond,
    input wire [7:0] i_warn_cond,
    input wire [7:0] i_group_fault,
    input wire i_spi_xfer,
    input wire [6:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] o_reg_rdata,
    input wire o_reg_rvalid,
    input wire o_reg_busy,
    input wire [15:0] o_spi_status,
    input wire [15:0] o_online_status,
    input wire o_irq
);
    localparam int RW = P_REMOTE_WAIT_CYC + 1;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////
    sequence s_rmt_rd;
        i_reg_rd && !i_reg_wr && !o_reg_busy && i_reg_addr == 7'h40;
    endsequence
    sequence s_rmt_done;
        o_reg_rvalid && !o_reg_busy;
    endsequence
    a_warn_mirror: assert property (!$past(i_rst) |-> o_online_status[7:0] == $past(i_warn_cond))
        else $error("online low half differs from live warnings");
    a_crit_mirror: assert property (!$past(i_rst) |-> o_online_status[15:9] == $past(i_crit_cond[7:1]))
        else $error("online high half differs from live criticals");
    a_spi_capture: assert property (i_spi_xfer |=> o_spi_status == o_online_status && o_spi_status[7:0] == $past(i_warn_cond))
        else $error("transfer status not captured");
    a_spi_hold: assert property (!i_spi_xfer |=> $stable(o_spi_status))
        else $error("transfer status moved without transfer");
    a_local_answer: assert property (i_reg_rd && !i_reg_wr && !o_reg_busy && i_reg_addr != 7'h40 |=> o_reg_rvalid)
        else $error("local read not answered next cycle");
    a_remote_busy: assert property (s_rmt_rd |=> o_reg_busy)
        else $error("remote access not busy");
    a_remote_answer: assert property (s_rmt_rd |-> ##RW s_rmt_done)
        else $error("remote read answer late or early");
    a_digest_rsvd: assert property (i_reg_rd && !i_reg_wr && !o_reg_busy && i_reg_addr == 7'h18 |=> o_reg_rdata[6:5] == 2'h0)
        else $error("reserved digest bits set");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(|i_crit_cond || |i_warn_cond || i_reg_wr, 2) || $past(|i_group_fault, 3))
        else $error("interrupt rose without cause");
endmodule

//--- sim/tb_top.sv
// Purpose: self-checking bench for fser_top
// Assumes: 20 MHz clock, remote wait shortened to 4 cycles
// Notes: reads queue their expected data, a negedge monitor compares
`timescale 1ns/1ps
module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] crit = 8'h00, warn = 8'h00, grp = 8'h00, rmt = 8'h00, wd = 8'h00, r;
    reg [6:0] ad = 7'h00;
    reg wr = 1'b0, rd = 1'b0;
    wire xfer, rv, busy, irq;
    wire [7:0] rdat;
    wire [15:0] spi, onl;
    integer err_total = 0, comparisons = 0, seed = 32'h2992665b, n;
    reg [7:0] exp_q[$];
    always #25 clk = ~clk;
    fser_top #(.P_REMOTE_WAIT_CYC(4)) dut_u (.i_core_clk(clk), .i_rst(rst),
        .i_crit_cond(crit), .i_warn_cond(warn), .i_group_fault(grp),
        .i_remote_fault_status(rmt), .i_spi_xfer(xfer), .i_reg_addr(ad), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
        .o_reg_busy(busy), .o_spi_status(spi), .o_online_status(onl), .o_irq(irq));
    fser_host_spi host_u (.i_core_clk(clk), .i_rst(rst), .o_spi_xfer(xfer));
    ////////////////////////////////////////////////////////////////
    task cmp(input string nm, input [15:0] e, input [15:0] s);
        begin
            comparisons = comparisons + 1;
            if (e !== s)
            begin
                err_total = err_total + 1;
                $display("unexpected %0s exp %h got %h", nm, e, s);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d comparisons %0d", err_total, comparisons);
            if (err_total == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task idle;
        begin
            n = 0;
            @(posedge clk);
            #1;
            while (busy !== 1'b0 && n < 100)
            begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
        end
    endtask
    task rreg(input [6:0] a, input [7:0] e);
        begin
            exp_q.push_back(e);
            @(posedge clk);
            ad <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            idle;
        end
    endtask
    task wreg(input [6:0] a, input [7:0] d);
        begin
            @(posedge clk);
            ad <= a;
            wd <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            idle;
        end
    endtask
    task pulse(input [7:0] c, input [7:0] w, input [7:0] m);
        begin
            @(posedge clk);
            crit <= c;
            warn <= w;
            rmt <= m;
            @(posedge clk);
            crit <= 8'h00;
            warn <= 8'h00;
            rmt <= 8'h00;
            repeat (3) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    always @(negedge clk)
        if (rv === 1'b1)
            cmp("rdata", {8'h00, exp_q.size() ? exp_q.pop_front() : 8'hXX}, {8'h00, rdat});
    initial
    begin
        #400000;
        err_total = err_total + 1;
        give_verdict;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rreg(7'h10, 8'h00);
        rreg(7'h13, 8'h00);
        rreg(7'h18, 8'h00);
        rreg(7'h20, 8'h00);
        rreg(7'h40, 8'h01);
        n = $random(seed);
        r = n[7:0] | 8'h01;
        pulse(8'h80, r, 8'h00);
        #1 cmp("online", 16'h0000, onl);
        rreg(7'h11, r);
        rreg(7'h10, 8'h80);
        wreg(7'h13, 8'hFF);
        cmp("irq", 16'h0001, {15'h0, irq});
        wreg(7'h11, 8'h00);
        cmp("irq", 16'h0000, {15'h0, irq});
        rreg(7'h11, 8'h00);
        @(posedge clk) warn <= 8'h04;
        wreg(7'h11, 8'h00);
        rreg(7'h11, 8'h04);
        cmp("online", 16'h0004, {8'h00, onl[7:0]});
        rreg(7'h15, 8'h04);
        @(posedge clk) warn <= 8'h00;
        wreg(7'h11, 8'h00);
        wreg(7'h10, 8'h00);
        rreg(7'h10, 8'h00);
        @(posedge clk) grp <= 8'hFF;
        rreg(7'h18, 8'h9F);
        rreg(7'h10, 8'h01);
        rreg(7'h14, 8'h01);
        @(posedge clk) grp <= 8'h00;
        rreg(7'h18, 8'h00);
        wreg(7'h12, 8'h01);
        cmp("irq", 16'h0001, {15'h0, irq});
        rreg(7'h12, 8'h01);
        wreg(7'h10, 8'h00);
        cmp("irq", 16'h0000, {15'h0, irq});
        pulse(8'h00, 8'h00, 8'h16);
        rreg(7'h40, 8'h17);
        wreg(7'h40, 8'h00);
        rreg(7'h40, 8'h00);
        repeat (2) @(posedge clk);
        n = exp_q.size();
        cmp("pending", 16'h0000, n[15:0]);
        give_verdict;
    end
endmodule
bind fser_top fser_chk #(.P_REMOTE_WAIT_CYC(P_REMOTE_WAIT_CYC)) chk_u (.*);

//--- verilog/fser_irq_gate.v
// Purpose: masks event bits onto one registered interrupt line
// Assumes: mask bit high enables the event
// Notes: line follows the masked events with one cycle of delay
`timescale 1ns/1ps

module fser_irq_gate #(
    parameter W = 16
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [W-1:0] i_event,
    input wire [W-1:0] i_mask,
    output reg o_irq
);

always @(posedge i_core_clk)
begin
    if (i_rst)
    begin
        o_irq <= 1'b0;
    end
    else
    begin
        o_irq <= |(i_event & i_mask);
    end
end

endmodule

//--- verilog/fser_map.vh
// Purpose: constants for the feedback status and event reporting block
// Assumes: 20 MHz core clock, 8-bit register data, 7-bit register address
// Notes: register offsets are byte addresses on the register access port
`ifndef FSER_MAP_VH
`define FSER_MAP_VH

// register offsets
`define FSER_OFF_EVENT_H 7'h10
`define FSER_OFF_EVENT_L 7'h11
`define FSER_OFF_MASK_H 7'h12
`define FSER_OFF_MASK_L 7'h13
`define FSER_OFF_ONLINE_H 7'h14
`define FSER_OFF_ONLINE_L 7'h15
`define FSER_OFF_DIGEST 7'h18
`define FSER_OFF_REMOTE0 7'h40

// field positions
`define FSER_BIT_AGG_FAULT 0
`define FSER_BIT_GRP_FAST_POS 0
`define FSER_BIT_GRP_SAFE_POS 1
`define FSER_BIT_GRP_INSTALL 2
`define FSER_BIT_GRP_MONITOR 3
`define FSER_BIT_GRP_RESOURCE 4
`define FSER_BIT_GRP_USER_WARN 7
`define FSER_BIT_RMT_PROTO_RST 0
`define FSER_BIT_RMT_ACCEL_OVR 1
`define FSER_BIT_RMT_TEST_RUN 2
`define FSER_BIT_RMT_TRACK_POS 4

// valid bits of the digest, reserved bits 5 and 6 read as zero
`define FSER_DIGEST_VALID 8'h9F

// reset values
`define FSER_RST_EVENT 8'h00
`define FSER_RST_MASK 8'h00
`define FSER_RST_DIGEST 8'h00
`define FSER_RST_REMOTE0 8'h01

// timing
`define FSER_CLK_KHZ 20000
`define FSER_REFRESH_US 200
`define FSER_REFRESH_CYC ((`FSER_REFRESH_US * `FSER_CLK_KHZ) / 1000)
`define FSER_REMOTE_US 1500
`define FSER_REMOTE_CYC ((`FSER_REMOTE_US * `FSER_CLK_KHZ) / 1000)

`endif

//--- verilog/fser_sticky.v
// Purpose: bank of sticky event bits, set by hardware, cleared by software
// Assumes: set and clear strobes come from logic on the same clock
// Notes: a write clears each bit whose write data bit is zero, unless the bit is set in the same cycle
`timescale 1ns/1ps

module fser_sticky #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [W-1:0] i_set,
    input wire i_clr_wr,
    input wire [W-1:0] i_keep,
    output reg [W-1:0] o_q
);

reg [W-1:0] q_nxt;

////////////////////////////////////////////////////////////////////////////////
// next value
always @*
begin
    q_nxt = o_q;
    if (i_clr_wr)
    begin
        q_nxt = o_q & i_keep;
    end
    q_nxt = q_nxt | i_set;
end

always @(posedge i_core_clk)
begin
    if (i_rst)
    begin
        o_q <= RST_VAL;
    end
    else
    begin
        o_q <= q_nxt;
    end
end

endmodule

//--- verilog/fser_top.v
// Purpose: status, event and error-group reporting of the feedback master
// Assumes: condition inputs come from protocol logic on i_core_clk
// Notes: remote group 0 accesses complete after P_REMOTE_WAIT_CYC cycles
`timescale 1ns/1ps
`include "fser_map.vh"

module fser_top #(
    parameter P_REMOTE_WAIT_CYC = `FSER_REMOTE_CYC
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [7:0] i_crit_cond,
    input wire [7:0] i_warn_cond,
    input wire [7:0] i_group_fault,
    input wire [7:0] i_remote_fault_status,
    input wire i_spi_xfer,
    input wire [6:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    output reg o_reg_busy,
    output reg [15:0] o_spi_status,
    output reg [15:0] o_online_status,
    output wire o_irq
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_REMOTE = 2'b10;
localparam [31:0] WAIT_LAST_W = P_REMOTE_WAIT_CYC - 1;
localparam [15:0] WAIT_LAST = WAIT_LAST_W[15:0];

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [15:0] wait_cnt_r;
reg [15:0] wait_cnt_nxt;
reg pend_wr_r;
reg pend_wr_nxt;
reg [7:0] pend_data_r;
reg [7:0] pend_data_nxt;
reg [7:0] digest_r;
reg [7:0] mask_h_r;
reg [7:0] mask_l_r;
reg [7:0] rdata_nxt;
reg rvalid_nxt;

wire [7:0] event_h;
wire [7:0] event_l;
wire [7:0] remote0;
wire [7:0] crit_set;
wire agg_fault;
wire [15:0] online_live;
wire idle_req;
wire wr_evh;
wire wr_evl;
wire wr_remote_done;

////////////////////////////////////////////////////////////////////////////////
// address decode
function hit;
    input [6:0] addr;
    input [6:0] off;
    begin
        hit = (addr == off);
    end
endfunction

assign idle_req = state_r[0] & (i_reg_wr | i_reg_rd);
assign wr_evh = state_r[0] & i_reg_wr & hit(i_reg_addr, `FSER_OFF_EVENT_H);
assign wr_evl = state_r[0] & i_reg_wr & hit(i_reg_addr, `FSER_OFF_EVENT_L);

////////////////////////////////////////////////////////////////////////////////
// error-group digest
always @(posedge i_core_clk)
begin
    if (i_rst)
    begin
        digest_r <= `FSER_RST_DIGEST;
    end
    else
    begin
        digest_r <= i_group_fault & `FSER_DIGEST_VALID;
    end
end

assign agg_fault = |digest_r;

////////////////////////////////////////////////////////////////////////////////
// event registers
// critical set sources
assign crit_set = {i_crit_cond[7:1], agg_fault | i_crit_cond[`FSER_BIT_AGG_FAULT]};

fser_sticky #(
    .W(8),
    .RST_VAL(`FSER_RST_EVENT)
) u_event_h (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(crit_set),
    .i_clr_wr(wr_evh),
    .i_keep(i_reg_wdata),
    .o_q(event_h)
);

fser_sticky #(
    .W(8),
    .RST_VAL(`FSER_RST_EVENT)
) u_event_l (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(i_warn_cond),
    .i_clr_wr(wr_evl),
    .i_keep(i_reg_wdata),
    .o_q(event_l)
);

////////////////////////////////////////////////////////////////////////////////
// masks and interrupt
always @(posedge i_core_clk)
begin
    if (i_rst)
    begin
        mask_h_r <= `FSER_RST_MASK;
        mask_l_r <= `FSER_RST_MASK;
    end
    else
    begin
        if (state_r[0] & i_reg_wr & hit(i_reg_addr, `FSER_OFF_MASK_H))
        begin
            mask_h_r <= i_reg_wdata;
        end
        if (state_r[0] & i_reg_wr & hit(i_reg_addr, `FSER_OFF_MASK_L))
        begin
            mask_l_r <= i_reg_wdata;
        end
    end
end

fser_irq_gate #(
    .W(16)
) u_irq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_event({event_h, event_l}),
    .i_mask({mask_h_r, mask_l_r}),
    .o_irq(o_irq)
);

////////////////////////////////////////////////////////////////////////////////
// online status
assign online_live = {crit_set, i_warn_cond};

always @(posedge i_core_clk)
begin
    if (i_rst)
    begin
        o_online_status <= 16'h0000;
        o_spi_status <= 16'h0000;
    end
    else
    begin
        o_online_status <= online_live;
        if (i_spi_xfer)
        begin
            o_spi_status <= online_live;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// remote fault group 0
assign wr_remote_done = state_r[1] & pend_wr_r & (wait_cnt_r == WAIT_LAST);

fser_sticky #(
    .W(8),
    .RST_VAL(`FSER_RST_REMOTE0)
) u_remote0 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(i_remote_fault_status),
    .i_clr_wr(wr_remote_done),
    .i_keep(pend_data_r),
    .o_q(remote0)
);

////////////////////////////////////////////////////////////////////////////////
// access sequencer
always @*
begin
    state_nxt = state_r;
    wait_cnt_nxt = wait_cnt_r;
    pend_wr_nxt = pend_wr_r;
    pend_data_nxt = pend_data_r;
    rdata_nxt = 8'h00;
    rvalid_nxt = 1'b0;
    case (state_r)
        ST_IDLE:
        begin
            if (idle_req & hit(i_reg_addr, `FSER_OFF_REMOTE0))
            begin
                state_nxt = ST_REMOTE;
                wait_cnt_nxt = 16'h0000;
                pend_wr_nxt = i_reg_wr;
                pend_data_nxt = i_reg_wdata;
            end
            else if (i_reg_rd & ~i_reg_wr)
            begin
                rvalid_nxt = 1'b1;
                case (i_reg_addr)
                    `FSER_OFF_EVENT_H: rdata_nxt = event_h;
                    `FSER_OFF_EVENT_L: rdata_nxt = event_l;
                    `FSER_OFF_MASK_H: rdata_nxt = mask_h_r;
                    `FSER_OFF_MASK_L: rdata_nxt = mask_l_r;
                    `FSER_OFF_ONLINE_H: rdata_nxt = online_live[15:8];
                    `FSER_OFF_ONLINE_L: rdata_nxt = online_live[7:0];
                    `FSER_OFF_DIGEST: rdata_nxt = digest_r;
                    default: rdata_nxt = 8'h00;
                endcase
            end
        end
        ST_REMOTE:
        begin
            if (wait_cnt_r == WAIT_LAST)
            begin
                state_nxt = ST_IDLE;
                rvalid_nxt = ~pend_wr_r;
                rdata_nxt = pend_wr_r ? 8'h00 : remote0;
                pend_wr_nxt = 1'b0;
            end
            else
            begin
                wait_cnt_nxt = wait_cnt_r + 16'h0001;
            end
        end
        default:
        begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge i_core_clk)
begin
    if (i_rst)
    begin
        state_r <= ST_IDLE;
        wait_cnt_r <= 16'h0000;
        pend_wr_r <= 1'b0;
        pend_data_r <= 8'hFF;
        o_reg_rdata <= 8'h00;
        o_reg_rvalid <= 1'b0;
        o_reg_busy <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        wait_cnt_r <= wait_cnt_nxt;
        pend_wr_r <= pend_wr_nxt;
        pend_data_r <= pend_data_nxt;
        o_reg_rdata <= rdata_nxt;
        o_reg_rvalid <= rvalid_nxt;
        o_reg_busy <= state_nxt[1];
    end
end

endmodule
